// ===== tws_regs.svh
// Constants for the two-wire memory slave: sizes, slave-address fields,
// bus timing figures and derived cycle counts. Definitions only.
`ifndef TWS_REGS_SVH
`define TWS_REGS_SVH

`define TWS_MEM_DEPTH 32768
`define TWS_ADDR_W 15
`define TWS_ADDR_LAST 15'h7FFF
`define TWS_ADDR_ZERO 15'h0000
`define TWS_TYPE_MSB 7
`define TWS_TYPE_LSB 4
`define TWS_SEL_MSB 3
`define TWS_SEL_LSB 1
`define TWS_RW_BIT 0
`define TWS_BIT_LAST 3'h7
`define TWS_BIT_ZERO 3'h0
`define TWS_SYS_CLK_HZ 10000000
`define TWS_SCL_MAX_HZ 1000000
// System clock cycles per fastest bus period; must be at least 4
`define TWS_SCL_MIN_CYCLES (`TWS_SYS_CLK_HZ / `TWS_SCL_MAX_HZ)

`endif

// ===== tws_pkg.sv
// Types shared by the two-wire memory slave modules.
// Constants live in tws_regs.svh; this package only holds types.
package tws_pkg;
	typedef enum logic [2:0] {
		TWS_IDLE,
		TWS_DEV,
		TWS_ADDR_HI,
		TWS_ADDR_LO,
		TWS_WR_DATA,
		TWS_RD_DATA,
		TWS_RD_ACK
	} tws_state_t;
endpackage

// ===== tws_sync.sv
// Two-flop synchroniser for the asynchronous bus and strap pins.
// Assumes the pins are unrelated to sys_clk_in.
`timescale 1ns/10ps
module tws_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	// First flop feeds only the second
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			meta_q <= INIT;
			sync_out <= INIT;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

// ===== tws_mem.sv
// Byte-wide storage array, one synchronous write and read port.
// Assumes the controller issues at most one access per cycle.
`timescale 1ns/10ps
`include "tws_regs.svh"
module tws_mem (
	input wire logic sys_clk_in,
	input wire logic wr_en_in,
	input wire logic [`TWS_ADDR_W-1:0] addr_in,
	input wire logic [7:0] wr_data_in,
	output logic [7:0] rd_data_out
);
	logic [7:0] mem_q [0:`TWS_MEM_DEPTH-1];

	// Contents are not reset: nonvolatile array
	always_ff @(posedge sys_clk_in) begin
		if (wr_en_in) begin
			mem_q[addr_in] <= wr_data_in;
		end
		rd_data_out <= mem_q[addr_in];
	end
endmodule

// ===== tws_slave.sv
// Two-wire serial slave front end of a 32768 x 8 nonvolatile memory.
// Assumes the bus master clocks every transfer; pins are asynchronous.
`timescale 1ns/10ps
`include "tws_regs.svh"
module tws_slave #(
	parameter logic [3:0] DEVICE_TYPE = 4'h5 // Arbitrary type code
) (
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n_out,
	input wire logic [2:0] device_select_straps_in,
	input wire logic write_protect_in,
	output logic selected_out
);
	logic scl_s;
	logic sda_s;
	logic [2:0] straps_s;
	logic wp_s;
	logic scl_q;
	logic sda_q;
	tws_pkg::tws_state_t state_q;
	tws_pkg::tws_state_t state_d;
	logic [2:0] bit_q;
	logic [7:0] shift_q;
	logic [7:0] tx_q;
	logic ack_phase_q;
	logic pull_low_q;
	logic [`TWS_ADDR_W-1:0] addr_q;
	logic sel_q;
	logic [7:0] rd_data;

	// Pins pass two flops; undriven pins are pulled low externally
	// Reset value matches idle lines: clock and data high, straps and
	// write-protect low, so no false edge or protection follows reset
	tws_sync #(.WIDTH(6), .INIT(6'h30)) u_sync (
		.sys_clk_in(sys_clk_in),
		.reset_n_in(reset_n_in),
		.async_in({scl_in, sda_in, device_select_straps_in,
			write_protect_in}),
		.sync_out({scl_s, sda_s, straps_s, wp_s})
	);

	// Previous samples for edge finding
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	// Bus conditions; 10x oversampling leaves margin at 1 MHz
	wire scl_rise = scl_s && !scl_q;
	wire scl_fall = !scl_s && scl_q;
	wire start_cond = scl_s && scl_q && sda_q && !sda_s;
	wire stop_cond = scl_s && scl_q && !sda_q && sda_s;
	wire byte_done = scl_rise && !ack_phase_q && (bit_q == `TWS_BIT_LAST);
	wire ack_rise = scl_rise && ack_phase_q;
	wire [7:0] rx_byte = {shift_q[6:0], sda_s};

	// Slave address decode
	wire type_ok = rx_byte[`TWS_TYPE_MSB:`TWS_TYPE_LSB] == DEVICE_TYPE;
	wire sel_ok = rx_byte[`TWS_SEL_MSB:`TWS_SEL_LSB] == straps_s;
	wire dir_rd = rx_byte[`TWS_RW_BIT];
	wire wr_ok = !wp_s;
	wire mem_we = byte_done && (state_q == tws_pkg::TWS_WR_DATA) && wr_ok;

	// Address advance wraps naturally at the top
	function automatic logic [`TWS_ADDR_W-1:0] next_addr(
		input logic [`TWS_ADDR_W-1:0] a
	);
		next_addr = (a == `TWS_ADDR_LAST) ? `TWS_ADDR_ZERO :
			a + 15'h0001;
	endfunction

	// Next state at end of byte and on master acknowledge
	always_comb begin
		state_d = state_q;
		if (byte_done) begin
			case (state_q)
				tws_pkg::TWS_DEV: begin
					if (type_ok && sel_ok) begin
						state_d = dir_rd ? tws_pkg::TWS_RD_DATA :
							tws_pkg::TWS_ADDR_HI;
					end else begin
						state_d = tws_pkg::TWS_IDLE;
					end
				end
				tws_pkg::TWS_ADDR_HI: state_d = tws_pkg::TWS_ADDR_LO;
				tws_pkg::TWS_ADDR_LO: state_d = tws_pkg::TWS_WR_DATA;
				tws_pkg::TWS_WR_DATA: begin
					state_d = wr_ok ? tws_pkg::TWS_WR_DATA :
						tws_pkg::TWS_IDLE;
				end
				tws_pkg::TWS_RD_DATA: state_d = tws_pkg::TWS_RD_ACK;
				default: state_d = state_q;
			endcase
		end else if (ack_rise && state_q == tws_pkg::TWS_RD_ACK) begin
			state_d = sda_s ? tws_pkg::TWS_IDLE :
				tws_pkg::TWS_RD_DATA;
		end
	end

	// Bus state; start restarts, stop aborts, anywhere
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			state_q <= tws_pkg::TWS_IDLE;
		end else if (start_cond) begin
			state_q <= tws_pkg::TWS_DEV;
		end else if (stop_cond) begin
			state_q <= tws_pkg::TWS_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Bit counter and acknowledge slot tracking
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in || start_cond) begin
			bit_q <= `TWS_BIT_ZERO;
			ack_phase_q <= 1'b0;
		end else if (byte_done) begin
			bit_q <= `TWS_BIT_ZERO;
			ack_phase_q <= 1'b1;
		end else if (ack_rise) begin
			ack_phase_q <= 1'b0;
		end else if (scl_rise) begin
			bit_q <= bit_q + 3'h1;
		end
	end

	// Receive shifter, MSB first
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			shift_q <= 8'h00;
		end else if (scl_rise && !ack_phase_q) begin
			shift_q <= rx_byte;
		end
	end

	// Address latch; top received bit is dropped
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			addr_q <= `TWS_ADDR_ZERO;
		end else if (byte_done && state_q == tws_pkg::TWS_ADDR_HI) begin
			addr_q <= {rx_byte[6:0], addr_q[7:0]};
		end else if (byte_done && state_q == tws_pkg::TWS_ADDR_LO) begin
			addr_q <= {addr_q[14:8], rx_byte};
		end else if (mem_we) begin
			addr_q <= next_addr(addr_q);
		end else if (ack_rise && state_q == tws_pkg::TWS_RD_ACK) begin
			addr_q <= next_addr(addr_q);
		end
	end

	// Array written in the cycle the eighth bit lands
	tws_mem u_mem (
		.sys_clk_in(sys_clk_in),
		.wr_en_in(mem_we),
		.addr_in(addr_q),
		.wr_data_in(rx_byte),
		.rd_data_out(rd_data)
	);

	// Read byte loaded at first fall of a read byte, shifted on falls
	wire rd_load = scl_fall && bit_q == `TWS_BIT_ZERO && !ack_phase_q &&
		state_q == tws_pkg::TWS_RD_DATA;
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			tx_q <= 8'hFF;
		end else if (rd_load) begin
			tx_q <= rd_data;
		end else if (scl_fall && state_q == tws_pkg::TWS_RD_DATA) begin
			tx_q <= {tx_q[6:0], 1'b1};
		end
	end

	// Pull-low request: ack slots we own, or zero read bits
	wire ack_slot = ack_phase_q && (state_q == tws_pkg::TWS_ADDR_HI ||
		state_q == tws_pkg::TWS_ADDR_LO || state_q == tws_pkg::TWS_WR_DATA ||
		state_q == tws_pkg::TWS_RD_DATA);
	wire rd_slot = !ack_phase_q && state_q == tws_pkg::TWS_RD_DATA;
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in || start_cond || stop_cond) begin
			pull_low_q <= 1'b0;
		end else if (scl_fall) begin
			if (rd_slot) begin
				pull_low_q <= rd_load ? !rd_data[7] : !tx_q[6];
			end else begin
				pull_low_q <= ack_slot;
			end
		end
	end

	// Mark when a read or write session owns the bus
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			sel_q <= 1'b0;
		end else begin
			sel_q <= state_q != tws_pkg::TWS_IDLE &&
				state_q != tws_pkg::TWS_DEV;
		end
	end

	// Open drain: drive low only, clock line is never driven
	assign sda_out = 1'b0;
	assign sda_oe_n_out = !pull_low_q;
	assign selected_out = sel_q;
endmodule

// ===== tws_slave_monitor.sv
// Pin checker for the two-wire slave, bound into every tws_slave.
// Assumes one system clock and a synchronous active-low reset.
`timescale 1ns/10ps
module tws_monitor (
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe_n_out,
	input wire logic selected_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!reset_n_in);
	// A pull must hold for at least four cycles once it starts
	sequence pull_held;
		!sda_oe_n_out [*4];
	endsequence
	sequence stop_seen;
		scl_in && $rose(sda_in);
	endsequence
	sequence start_seen;
		scl_in && $fell(sda_in);
	endsequence
	sda_low_a: assert property (sda_out == 1'b0)
		else $error("data pin value not low");
	reset_idle_a: assert property (disable iff (1'b0)
		!reset_n_in |=> sda_oe_n_out && !selected_out)
		else $error("reset did not leave the pins idle");
	reset_quiet_a: assert property ($rose(reset_n_in)
		|-> sda_oe_n_out [*3]) else $error("pull right after reset");
	edge_low_a: assert property ($changed(sda_oe_n_out) |-> !scl_in)
		else $error("data pull changed with clock high");
	edge_lag_a: assert property ($fell(sda_oe_n_out)
		|-> !$past(scl_in, 3)) else $error("pull too soon after edge");
	pull_held_a: assert property ($fell(sda_oe_n_out) |-> pull_held)
		else $error("pull released too early");
	stop_drop_a: assert property (stop_seen |-> ##[1:6] !selected_out)
		else $error("still selected after stop");
	start_free_a: assert property (start_seen |-> ##[1:6] sda_oe_n_out)
		else $error("data held low after start");
endmodule
bind tws_slave tws_monitor mon_u (.sys_clk_in(sys_clk_in),
	.reset_n_in(reset_n_in), .scl_in(scl_in), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
	.selected_out(selected_out));

// ===== tws_master.sv
// Behavioural two-wire bus master driving the slave under test.
// Assumes the bench resolves the pulled-up data wire.
`timescale 1ns/10ps
module tws_master (
	input wire logic sys_clk_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_oe_n_out
);
	// Both lines idle released; the clock stands high between frames
	initial begin
		scl_out = 1'b1;
		sda_oe_n_out = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge sys_clk_in);
	endtask
	// Long low phase leaves room for the slave's pin lag
	task automatic bit_io(input logic v, output logic s);
		wt(2);
		sda_oe_n_out = v;
		wt(4);
		scl_out = 1'b1;
		wt(1);
		s = sda_in;
		wt(1);
		scl_out = 1'b0;
	endtask
	task automatic bus_start();
		wt(2);
		sda_oe_n_out = 1'b1;
		wt(2);
		scl_out = 1'b1;
		wt(2);
		sda_oe_n_out = 1'b0;
		wt(2);
		scl_out = 1'b0;
	endtask
	task automatic bus_stop();
		wt(2);
		sda_oe_n_out = 1'b0;
		wt(2);
		scl_out = 1'b1;
		wt(2);
		sda_oe_n_out = 1'b1;
		wt(2);
	endtask
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], s);
		end
		bit_io(1'b1, s);
		ack = !s;
	endtask
	// Acknowledge asks for more; leaving it off ends the read
	task automatic recv_byte(input logic more, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(!more, s);
	endtask
endmodule

// ===== tws_slave_bench.sv
// Self-checking bench: the slave against a behavioural bus master.
// Assumes the slave's default type code and a pulled-up data wire.
`timescale 1ns/10ps
module tws_slave_bench;
	localparam logic [2:0] STRAPS = 3'h6;
	localparam logic [7:0] DEV_W = {4'h5, STRAPS, 1'b0};
	logic sys_clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic write_protect_in = 1'b0;
	logic scl, m_oe_n, sda_w, sda_out, sda_oe_n_out, selected_out;
	int failures = 0;
	int n_tests = 0;
	// Pull-up wins unless a party pulls low
	assign sda_w = !m_oe_n ? 1'b0 : (!sda_oe_n_out ? sda_out : 1'b1);
	always #50 sys_clk_in = ~sys_clk_in;
	tws_slave dut_u (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
		.scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
		.sda_oe_n_out(sda_oe_n_out), .device_select_straps_in(STRAPS),
		.write_protect_in(write_protect_in), .selected_out(selected_out));
	tws_master m_u (.sys_clk_in(sys_clk_in), .sda_in(sda_w),
		.scl_out(scl), .sda_oe_n_out(m_oe_n));
	task automatic give_verdict();
		$display("failures %0d n_tests %0d", failures, n_tests);
		if (failures == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic put(input logic [7:0] b, input logic ak);
		logic a;
		m_u.send_byte(b, a);
		check8({7'h0, a}, {7'h0, ak});
	endtask
	task automatic get(input logic more, input logic [7:0] exp);
		logic [7:0] d;
		m_u.recv_byte(more, d);
		check8(d, exp);
	endtask
	// Open a write and load the address
	task automatic aim(input logic [7:0] hi, input logic [7:0] lo);
		m_u.bus_start();
		put(DEV_W, 1'b1);
		put(hi, 1'b1);
		put(lo, 1'b1);
	endtask
	task automatic t_reset();
		repeat (4) @(negedge sys_clk_in);
		reset_n_in = 1'b1;
		repeat (4) @(negedge sys_clk_in);
		check8({6'h0, sda_oe_n_out, selected_out}, 8'h02);
	endtask
	// Top address bit set, bytes run across the last location
	task automatic t_wrap();
		aim(8'hFF, 8'hFE);
		check8({7'h0, selected_out}, 8'h01);
		put(8'hA1, 1'b1);
		put(8'hB2, 1'b1);
		put(8'hC3, 1'b1);
		m_u.bus_stop();
		aim(8'h7F, 8'hFE);
		m_u.bus_start();
		put(DEV_W | 8'h01, 1'b1);
		get(1'b1, 8'hA1);
		get(1'b1, 8'hB2);
		get(1'b0, 8'hC3);
		m_u.bus_stop();
		m_u.wt(4);
		check8({7'h0, selected_out}, 8'h00);
	endtask
	// Wrong select bits, then wrong type code
	task automatic t_refuse();
		logic [7:0] bad [2] = '{8'h52, 8'h3C};
		foreach (bad[i]) begin
			m_u.bus_start();
			put(bad[i], 1'b0);
			put(8'h00, 1'b0);
			check8({7'h0, selected_out}, 8'h00);
			m_u.bus_stop();
		end
	endtask
	// Refused byte must neither land nor move the address
	task automatic t_protect();
		aim(8'h00, 8'h10);
		put(8'h11, 1'b1);
		write_protect_in = 1'b1;
		aim(8'h00, 8'h10);
		put(8'h55, 1'b0);
		m_u.bus_stop();
		write_protect_in = 1'b0;
		m_u.bus_start();
		put(DEV_W | 8'h01, 1'b1);
		get(1'b0, 8'h11);
		m_u.bus_stop();
	endtask
	// Whole run is about 27 bytes of 7.2 us each
	initial begin
		#1000000;
		failures++;
		give_verdict();
	end
	initial begin
		t_reset();
		t_wrap();
		t_refuse();
		t_protect();
		give_verdict();
	end
endmodule
